// *** shared/ctrl_word_pkg.sv ***
`default_nettype none
package ctrl_word_pkg;

   // Chain lengths in stage positions, position 1 being the stage nearest the data input.
   localparam int TXFIL_LEN = 32;
   localparam int TRX_LEN   = 64;
   localparam int TIF_LEN   = 24;
   localparam int WR_LEN    = 16;
   localparam int WR_COUNT  = 2;

   // Synchroniser depth and pin slots of the synchronised input vector.
   localparam int SYNC_DEPTH   = 3;
   localparam int PIN_COUNT    = 7;
   localparam int PIN_SHIFT    = 0;
   localparam int PIN_LATCH    = 1;
   localparam int PIN_DATA1    = 2;
   localparam int PIN_DATA2    = 3;
   localparam int PIN_GATE1    = 5;
   localparam int PIN_GATE2    = 6;

   // Transmit filter chain positions; the second register's printed 17..24 sit at 25..32.
   localparam int TXF_AMP       = 17;
   localparam int TXF_DRV       = 18;
   localparam int TXF_CHK_SEL   = 20;
   localparam int TXF_MUX_DIS   = 23;
   localparam int TXF_REG2_BASE = 8;
   localparam int TXF_LPF       = 17;
   localparam int TXF_BREAKIN   = 24;

   // Transceiver chain positions.
   localparam int TRX_STROBE    = 1;
   localparam int TRX_POWER     = 17;
   localparam int TRX_RF_GAIN   = 27;
   localparam int TRX_PRESEL    = 33;
   localparam int TRX_BPF       = 41;
   localparam int TRX_TX_EN     = 49;
   localparam int TRX_RX_EN     = 50;
   localparam int TRX_SC_DEMOD  = 51;
   localparam int TRX_FC_DEMOD  = 52;
   localparam int TRX_IF_BW     = 54;
   localparam int TRX_FAST_DECAY_SELECT  = 57;
   localparam int TRX_NB        = 58;
   localparam int TRX_AGC_OFF   = 59;
   localparam int TRX_CARRIER   = 60;
   localparam int TRX_CHK_SEL   = 61;
   localparam int TRX_CHK_DIS   = 64;
   localparam int TRX_BAND_STB  = 1;

   // Band register positions, loaded from transceiver positions 17..24.
   localparam int BAND_VCO      = 17;
   localparam int BAND_HALF     = 21;
   localparam int BAND_TEST     = 24;

   // Terminal interface chain positions.
   localparam int TIF_STB_AUDIO = 11;
   localparam int TIF_STB_CPL   = 12;
   localparam int TIF_EXT_AUDIO = 22;
   localparam int TIF_TX_AUDIO  = 23;
   localparam int TIF_LINE_OUT  = 24;
   localparam int TIF_KEY       = 17;
   localparam int TIF_CPL_CMD   = 18;
   localparam int TIF_STAT_SEL  = 21;
   localparam int TIF_STAT_DIS  = 24;

   // Watch receiver chain positions.
   localparam int WR_LOAD       = 1;
   localparam int WR_STB_BAND   = 3;
   localparam int WR_STB_PLL    = 4;
   localparam int WR_BAND       = 9;
   localparam int WR_HALF       = 13;
   localparam int WR_TEST       = 14;
   localparam int WR_RF_FILTER  = 15;

   // Transmit filter board controls.
   typedef struct packed {
      logic       final_amp_enable;
      logic       driver_stage_power;
      logic [2:0] amp_check_sel;
      logic [1:0] mux_disable;
      logic [6:0] lpf_band_sel;
      logic       breakin_relay_drive;
   } txfil_ctrl_s;

   // Transceiver board controls.
   typedef struct packed {
      logic [7:0] power_code;
      logic [5:0] rf_gain_code;
      logic [7:0] preselector_cap_bit;
      logic [4:0] bpf_sel;
      logic       tx_enable;
      logic       rx_enable;
      logic       suppressed_carrier_demod_sel;
      logic       full_carrier_demod_sel;
      logic [2:0] if_bw_sel;
      logic       fast_decay_select;
      logic       noise_blanker_on;
      logic       agc_disable;
      logic       carrier_insert;
      logic [2:0] check_sel;
      logic       check_disable;
   } trx_ctrl_s;

   // Band register behind the transceiver's first strobe.
   typedef struct packed {
      logic [3:0] vco_band;
      logic       upper_half;
      logic       self_test_enable;
   } band_ctrl_s;

   // Terminal interface controls, two downstream registers.
   typedef struct packed {
      logic       external_audio_select;
      logic       tx_audio_source_select;
      logic       line_out_source_select;
      logic       external_keying_out;
      logic [2:0] coupler_cmd;
      logic [2:0] coupler_status_sel;
      logic       coupler_status_disable;
   } tif_ctrl_s;

   // Watch receiver controls.
   typedef struct packed {
      logic [1:0] synth_load;
      logic       pll_latch;
      logic [3:0] band_sel;
      logic       upper_half;
      logic       self_test_enable;
      logic [1:0] rf_filter_sel;
   } wr_ctrl_s;

endpackage
`default_nettype wire

// *** rtl/shift_latch_chain.sv ***
`default_nettype none
// One board's shift chain with its holding latch.
module shift_latch_chain
   import ctrl_word_pkg::*;
#(
   parameter int LEN = 24
)(
   input  wire logic           clk,
   input  wire logic           rst_n,
   input  wire logic           shift,
   input  wire logic           din,
   input  wire logic           load,
   output logic [LEN-1:0]      held
);

   logic [LEN-1:0] stage;       // Bits in flight; index 0 is position 1.
   logic [LEN-1:0] next_stage;  // Stage contents after this cycle.
   logic [LEN-1:0] next_held;   // Latch contents after this cycle.

   // New bits enter at position 1 and move toward the far end; the latch only follows
   // the stages on a load, so the parallel side never shows a half-shifted word.
   always_comb
   begin
      next_stage = stage;
      next_held  = held;
      if (shift)
      begin
         next_stage = {stage[LEN-2:0], din};
      end
      if (load)
      begin
         next_held = stage;
      end
   end

   // Registers of the chain.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage <= '0;
         held  <= '0;
      end
      else
      begin
         stage <= next_stage;
         held  <= next_held;
      end
   end

endmodule
`default_nettype wire

// *** rtl/serial_control_word_distributor.sv ***
`default_nettype none
module serial_control_word_distributor
   import ctrl_word_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 shift_clock,
   input  wire logic                 latch_strobe,
   input  wire logic                 serial_data_first,
   input  wire logic                 serial_data_second,
   input  wire logic                 serial_data_third,
   input  wire logic                 strobe_gate_first,
   input  wire logic                 strobe_gate_second,
   output txfil_ctrl_s               txfil_ctrl,
   output trx_ctrl_s                 trx_ctrl,
   output logic [4:0]                trx_strobe,
   output band_ctrl_s                band_ctrl,
   output tif_ctrl_s                 tif_ctrl,
   output wr_ctrl_s [WR_COUNT-1:0]   wr_ctrl
);

   logic [PIN_COUNT-1:0]  pin_raw;        // Pins gathered for the synchronisers.
   logic [PIN_COUNT-1:0]  sync_a;         // First synchroniser stage.
   logic [PIN_COUNT-1:0]  sync_b;         // Second synchroniser stage.
   logic [PIN_COUNT-1:0]  sync_c;         // Third synchroniser stage.
   logic [PIN_COUNT-1:0]  pin_level;      // Accepted level per pin.
   logic [PIN_COUNT-1:0]  next_pin_level; // Level after this cycle.
   logic [PIN_COUNT-1:0]  pin_rise;       // Accepted rising edge this cycle.
   logic                  shift_pulse;    // One shift per rising shift clock.
   logic                  load_pulse;     // One latch per rising latch strobe.

   // Only the accepted levels are read below.
   // The raw pins never reach the chains.

   logic [TXFIL_LEN-1:0]  txfil_bits;     // Transmit filter latch contents.
   logic [TRX_LEN-1:0]    trx_bits;       // Transceiver latch contents.
   logic [TIF_LEN-1:0]    tif_bits;       // Terminal interface latch contents.
   logic [WR_LEN-1:0]     wr_bits [WR_COUNT];  // Watch receiver latch contents.

   logic [2:0]            gate_lvl;       // Band, audio and coupler gated strobes.
   logic [2:0]            gate_prev;      // Same strobes one cycle earlier.
   logic [2:0]            next_gate_prev; // Next value of gate_prev.
   logic [WR_COUNT-1:0]   wr_gate_lvl;    // Receiver band gated strobes.
   logic [WR_COUNT-1:0]   wr_gate_prev;   // Same one cycle earlier.

   // Next values of the stream-one outputs.

   txfil_ctrl_s           next_txfil_ctrl;
   trx_ctrl_s             next_trx_ctrl;
   logic [4:0]            next_trx_strobe;
   band_ctrl_s            next_band_ctrl;
   tif_ctrl_s             next_tif_ctrl;

   // Slot order follows the pin slots of the package.
   // A glitch shorter than one clock is never seen.
   assign pin_raw = {strobe_gate_second, strobe_gate_first, serial_data_third,
                     serial_data_second, serial_data_first, latch_strobe, shift_clock};

   // Three-flop synchronisers; a pin counts as changed only when the last two stages agree,
   // which also rejects a single-cycle glitch on the shift clock wire.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_a    <= '0;
         sync_b    <= '0;
         sync_c    <= '0;
         pin_level <= '0;

      end
      else
      begin
         sync_a    <= pin_raw;
         sync_b    <= sync_a;
         sync_c    <= sync_b;

         pin_level <= next_pin_level;
      end
   end

   // A level that flips back before both agree is dropped on purpose.
   // Accept a new level only when stages two and three match.
   always_comb
   begin
      next_pin_level = pin_level;
      pin_rise       = '0;
      for (int i = 0; i < PIN_COUNT; i++)
      begin
         if (sync_b[i] == sync_c[i])
         begin
            next_pin_level[i] = sync_c[i];
            pin_rise[i]       = sync_c[i] & ~pin_level[i];
         end
      end
   end

   // Both pulses last one clock.
   // A pin held high gives no second pulse.
   assign shift_pulse = pin_rise[PIN_SHIFT];
   assign load_pulse  = pin_rise[PIN_LATCH];

   // Stream one drives all three boards on its branch; each has a chain of its own.
   shift_latch_chain #(.LEN(TXFIL_LEN)) u_txfil_chain
   (
      .clk   (clk),
      .rst_n (rst_n),
      .shift (shift_pulse),
      .din   (pin_level[PIN_DATA1]),
      .load  (load_pulse),
      .held  (txfil_bits)
   );

   // The transceiver chain is the longest.
   shift_latch_chain #(.LEN(TRX_LEN)) u_trx_chain
   (
      .clk   (clk),
      .rst_n (rst_n),
      .shift (shift_pulse),
      .din   (pin_level[PIN_DATA1]),
      .load  (load_pulse),
      .held  (trx_bits)
   );

   // The terminal chain needs only 24 stages.
   shift_latch_chain #(.LEN(TIF_LEN)) u_tif_chain
   (
      .clk   (clk),
      .rst_n (rst_n),
      .shift (shift_pulse),
      .din   (pin_level[PIN_DATA1]),
      .load  (load_pulse),
      .held  (tif_bits)
   );

   // Gated strobes for the downstream registers; a strobe fires only while its gate is high.
   assign gate_lvl[0] = trx_bits[TRX_BAND_STB-1] & pin_level[PIN_GATE1];
   assign gate_lvl[1] = tif_bits[TIF_STB_AUDIO-1] & pin_level[PIN_GATE1];
   assign gate_lvl[2] = tif_bits[TIF_STB_CPL-1] & pin_level[PIN_GATE1];

   // Decode of the stream-one boards and their downstream registers.
   always_comb
   begin
      next_gate_prev = gate_lvl;

      next_txfil_ctrl.final_amp_enable    = txfil_bits[TXF_AMP-1];
      next_txfil_ctrl.driver_stage_power  = txfil_bits[TXF_DRV-1];
      next_txfil_ctrl.amp_check_sel       = txfil_bits[TXF_CHK_SEL-1 +: 3];
      next_txfil_ctrl.mux_disable         = txfil_bits[TXF_MUX_DIS-1 +: 2];
      // Index 0 of the band select is the highest band.
      next_txfil_ctrl.lpf_band_sel        =
         txfil_bits[TXF_REG2_BASE+TXF_LPF-1 +: 7];
      next_txfil_ctrl.breakin_relay_drive =
         txfil_bits[TXF_REG2_BASE+TXF_BREAKIN-1];

      // The strobes are levels, not pulses.

      next_trx_strobe = trx_bits[TRX_STROBE-1 +: 5] & {5{pin_level[PIN_GATE1]}};

      next_trx_ctrl.power_code          = trx_bits[TRX_POWER-1 +: 8];
      next_trx_ctrl.rf_gain_code        = trx_bits[TRX_RF_GAIN-1 +: 6];

      // Position 33 is capacitor bit eight, so the field is reversed into place.
      for (int i = 0; i < 8; i++)
      begin
         next_trx_ctrl.preselector_cap_bit[7-i] = trx_bits[TRX_PRESEL-1+i];
      end

      next_trx_ctrl.bpf_sel             = trx_bits[TRX_BPF-1 +: 5];

      next_trx_ctrl.tx_enable           = trx_bits[TRX_TX_EN-1];
      next_trx_ctrl.rx_enable           = trx_bits[TRX_RX_EN-1];

      next_trx_ctrl.suppressed_carrier_demod_sel = trx_bits[TRX_SC_DEMOD-1];
      next_trx_ctrl.full_carrier_demod_sel       = trx_bits[TRX_FC_DEMOD-1];

      next_trx_ctrl.if_bw_sel           = trx_bits[TRX_IF_BW-1 +: 3];

      next_trx_ctrl.fast_decay_select   = trx_bits[TRX_FAST_DECAY_SELECT-1];
      next_trx_ctrl.noise_blanker_on    = trx_bits[TRX_NB-1];
      next_trx_ctrl.agc_disable         = trx_bits[TRX_AGC_OFF-1];
      next_trx_ctrl.carrier_insert      = trx_bits[TRX_CARRIER-1];
      next_trx_ctrl.check_sel           = trx_bits[TRX_CHK_SEL-1 +: 3];
      next_trx_ctrl.check_disable       = trx_bits[TRX_CHK_DIS-1];

      // Downstream registers take positions 17..24 only on a gated strobe's rising edge,
      // so they hold while the chain is reloaded for other purposes.
      // One load per gated rise.
      next_band_ctrl = band_ctrl;
      if (gate_lvl[0] && !gate_prev[0])
      begin
         next_band_ctrl.vco_band         = trx_bits[BAND_VCO-1 +: 4];
         next_band_ctrl.upper_half       = trx_bits[BAND_HALF-1];
         next_band_ctrl.self_test_enable = trx_bits[BAND_TEST-1];
      end
      else
      begin
         next_band_ctrl = band_ctrl;
      end


      // Audio and coupler registers load apart.
      next_tif_ctrl = tif_ctrl;
      if (gate_lvl[1] && !gate_prev[1])
      begin
         next_tif_ctrl.external_audio_select  = tif_bits[TIF_EXT_AUDIO-1];
         next_tif_ctrl.tx_audio_source_select = tif_bits[TIF_TX_AUDIO-1];
         next_tif_ctrl.line_out_source_select = tif_bits[TIF_LINE_OUT-1];
      end
      if (gate_lvl[2] && !gate_prev[2])
      begin
         next_tif_ctrl.external_keying_out    = tif_bits[TIF_KEY-1];
         next_tif_ctrl.coupler_cmd            = tif_bits[TIF_CPL_CMD-1 +: 3];
         next_tif_ctrl.coupler_status_sel     = tif_bits[TIF_STAT_SEL-1 +: 3];
         next_tif_ctrl.coupler_status_disable = tif_bits[TIF_STAT_DIS-1];
      end
   end

   // Every top output leaves straight from a flip-flop.
   // Output registers for the stream-one boards.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gate_prev  <= '0;
         txfil_ctrl <= '0;
         trx_ctrl   <= '0;
         trx_strobe <= '0;
         band_ctrl  <= '0;
         tif_ctrl   <= '0;
      end
      else
      begin
         gate_prev  <= next_gate_prev;

         txfil_ctrl <= next_txfil_ctrl;
         trx_ctrl   <= next_trx_ctrl;
         trx_strobe <= next_trx_strobe;
         band_ctrl  <= next_band_ctrl;
         tif_ctrl   <= next_tif_ctrl;
      end
   end

   // Gate two serves both receivers.
   // Watch receivers: stream two feeds the first, stream three the second.
   genvar w;
   generate
      for (w = 0; w < WR_COUNT; w++)
      begin : g_wr
         wr_ctrl_s next_wr; // Receiver outputs after this cycle.

         // Each receiver has a chain of its own.

         shift_latch_chain #(.LEN(WR_LEN)) u_wr_chain
         (
            .clk   (clk),
            .rst_n (rst_n),
            .shift (shift_pulse),
            .din   (pin_level[PIN_DATA2+w]),
            .load  (load_pulse),
            .held  (wr_bits[w])
         );

         // Band fields load on the gated rising edge.
         assign wr_gate_lvl[w] = wr_bits[w][WR_STB_BAND-1] & pin_level[PIN_GATE2];

         // Load strobes pass ungated; the latch strobes use the second gate line.
         always_comb
         begin
            // Fields not loaded below keep their value.
            next_wr            = wr_ctrl[w];
            next_wr.synth_load = wr_bits[w][WR_LOAD-1 +: 2];
            next_wr.pll_latch  = wr_bits[w][WR_STB_PLL-1] & pin_level[PIN_GATE2];

            if (wr_gate_lvl[w] && !wr_gate_prev[w])
            begin
               next_wr.band_sel         = wr_bits[w][WR_BAND-1 +: 4];
               next_wr.upper_half       = wr_bits[w][WR_HALF-1];
               next_wr.self_test_enable = wr_bits[w][WR_TEST-1];
               next_wr.rf_filter_sel    = wr_bits[w][WR_RF_FILTER-1 +: 2];
            end
         end

         // Receiver output registers.
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               wr_ctrl[w]      <= '0;
               wr_gate_prev[w] <= 1'b0;
            end
            else
            begin
               wr_ctrl[w]      <= next_wr;
               wr_gate_prev[w] <= wr_gate_lvl[w];
            end
         end
      end
   endgenerate

   // Limitation: the frame must be complete before the latch pin rises.
   // The stages are copied at the edge where the latch pulse is seen.
   // A shift seen in that same cycle is not in the copy.
   // Trade-off: filtering costs about four clocks per pin.
   // The pins are slow, so the delay is harmless.
   // Gate lines are taken active high.
   // Downstream registers react to edges, not levels.
   // A strobe bit left high loads its register once while its gate stays open.
   // Reset clears every output and every stage.

endmodule
`default_nettype wire

// *** tb/ctl_model.sv ***
`default_nettype none
// Behavioural main processor: drives the three streams, the shift clock and the latch pin.
module ctl_model
(
   input  wire logic clk,
   output logic      shift_clock,
   output logic      latch_strobe,
   output logic      data_first,
   output logic      data_second,
   output logic      data_third
);
   timeunit 1ns;
   timeprecision 1ps;

   // Pins start low; the shift clock stands still between frames.
   initial
   begin
      shift_clock = 1'b0;
      latch_strobe = 1'b0;
      data_first = 1'b0;
      data_second = 1'b0;
      data_third = 1'b0;
   end

   // Every change lands one nanosecond after a rising clock edge.
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Sends 64 shifts, far position first, so position k ends up holding bit k.
   task automatic send(input logic [64:1] a, input logic [16:1] b, input logic [16:1] c);
      for (int i = 64; i >= 1; i--)
      begin
         data_first = a[i];
         // Receiver streams carry filler first; it is pushed out of the short chains.
         data_second = (i <= 16) ? b[i] : ~data_second;
         data_third = (i <= 16) ? c[i] : ~data_third;
         wait_cyc(5);
         shift_clock = 1'b1;
         wait_cyc(5);
         shift_clock = 1'b0;
      end
      // After the frame the lines carry nothing useful, so they are flipped.
      data_first = ~data_first;
      data_second = ~data_second;
      data_third = ~data_third;
   endtask

   // One latch pulse, held long enough for the synchroniser on the far side.
   task automatic latch();
      latch_strobe = 1'b1;
      wait_cyc(6);
      latch_strobe = 1'b0;
      wait_cyc(6);
   endtask
endmodule
`default_nettype wire

// *** tb/distributor_assertions.sv ***
`default_nettype none
// Timing relations between the pins and the latched controls.
module distributor_assertions
   import ctrl_word_pkg::*;
(
   input wire logic                    clk,
   input wire logic                    rst_n,
   input wire logic                    latch_strobe,
   input wire logic                    strobe_gate_first,
   input wire logic                    strobe_gate_second,
   input wire txfil_ctrl_s             txfil_ctrl,
   input wire trx_ctrl_s               trx_ctrl,
   input wire logic [4:0]              trx_strobe,
   input wire band_ctrl_s              band_ctrl,
   input wire tif_ctrl_s               tif_ctrl,
   input wire wr_ctrl_s [WR_COUNT-1:0] wr_ctrl
);
   logic [4:0] idle_age;      // Cycles since the latch pin was last high.
   logic [4:0] next_idle_age; // Saturates so it never wraps into a false window.

   // Age counter; it starts saturated because reset leaves nothing pending.
   always_comb
   begin
      next_idle_age = idle_age;
      if (latch_strobe)
         next_idle_age = 5'h00;
      else if (idle_age != 5'h1f)
         next_idle_age = idle_age + 5'h01;
   end

   // Register for the age counter.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         idle_age <= 5'h1f;
      else
         idle_age <= next_idle_age;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_trx_hold: assert property (idle_age > 5'h02 |-> $stable(trx_ctrl))
      else $error("transceiver controls moved without a latch");
   a_txfil_hold: assert property (idle_age > 5'h02 |-> $stable(txfil_ctrl))
      else $error("filter board controls moved without a latch");
   a_synth_hold: assert property (idle_age > 5'h02 |->
      $stable({wr_ctrl[1].synth_load, wr_ctrl[0].synth_load}))
      else $error("synth load levels moved without a latch");
   a_strobe_gated: assert property (!strobe_gate_first [*8] |-> trx_strobe == 5'h00)
      else $error("transceiver strobe high with its gate closed");
   a_strobe_closes: assert property ($fell(strobe_gate_first) |-> ##[1:6] trx_strobe == 5'h00)
      else $error("transceiver strobes did not drop after gate closed");
   a_pll_gated: assert property (!strobe_gate_second [*8] |->
      !wr_ctrl[0].pll_latch && !wr_ctrl[1].pll_latch)
      else $error("receiver pll latch high with its gate closed");
   a_band_hold: assert property (!strobe_gate_first [*8] |-> $stable(band_ctrl))
      else $error("band register loaded with gate closed");
   a_tif_hold: assert property (!strobe_gate_first [*8] |-> $stable(tif_ctrl))
      else $error("terminal registers loaded with gate closed");
   a_wr_band_hold: assert property (!strobe_gate_second [*8] |->
      $stable({wr_ctrl[1][7:0], wr_ctrl[0][7:0]}))
      else $error("receiver band fields loaded with gate closed");

   cover property ($rose(latch_strobe));
   cover property ($changed(band_ctrl));
   cover property ($changed(tif_ctrl));
   cover property (trx_strobe != 5'h00);
endmodule

bind serial_control_word_distributor distributor_assertions chk (
   .clk(clk), .rst_n(rst_n), .latch_strobe(latch_strobe),
   .strobe_gate_first(strobe_gate_first), .strobe_gate_second(strobe_gate_second),
   .txfil_ctrl(txfil_ctrl), .trx_ctrl(trx_ctrl), .trx_strobe(trx_strobe),
   .band_ctrl(band_ctrl), .tif_ctrl(tif_ctrl), .wr_ctrl(wr_ctrl)
);
`default_nettype wire

// *** tb/tb.sv ***
`default_nettype none
module tb
   import ctrl_word_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

`define CHK(nm, ex, got) \
   begin \
      if ((got) !== (ex)) \
      begin \
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
         error_cnt++; \
      end \
      total_checks++; \
   end

   logic                    clk;
   logic                    rst_n;
   logic                    gate1;
   logic                    gate2;
   logic                    sck;
   logic                    lat;
   logic [2:0]              sd;
   txfil_ctrl_s             txfil_ctrl;
   trx_ctrl_s               trx_ctrl;
   logic [4:0]              trx_strobe;
   band_ctrl_s              band_ctrl;
   tif_ctrl_s               tif_ctrl;
   wr_ctrl_s [WR_COUNT-1:0] wr_ctrl;
   txfil_ctrl_s             e_tx;   // Expected values, worked out from the words sent.
   trx_ctrl_s               e_trx;
   logic [4:0]              e_stb;
   band_ctrl_s              e_band;
   tif_ctrl_s               e_tif;
   wr_ctrl_s [WR_COUNT-1:0] e_wr;
   logic [64:1]             w1;     // Bit k is the value meant for position k.
   logic [16:1]             w2;
   logic [16:1]             w3;
   logic [1:0]              go;     // Which gate lines open this round.
   int                      error_cnt = 0;
   int                      total_checks = 0;
   int                      cycles = 0;
   int                      seed = 25741;

   // Free-running 100 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   ctl_model ctl (.clk(clk), .shift_clock(sck), .latch_strobe(lat),
      .data_first(sd[0]), .data_second(sd[1]), .data_third(sd[2]));

   serial_control_word_distributor dut (.clk(clk), .rst_n(rst_n), .shift_clock(sck),
      .latch_strobe(lat), .serial_data_first(sd[0]), .serial_data_second(sd[1]),
      .serial_data_third(sd[2]), .strobe_gate_first(gate1), .strobe_gate_second(gate2),
      .txfil_ctrl(txfil_ctrl), .trx_ctrl(trx_ctrl), .trx_strobe(trx_strobe),
      .band_ctrl(band_ctrl), .tif_ctrl(tif_ctrl), .wr_ctrl(wr_ctrl));

   // Filter board fields; its second register sits at chain positions 25 to 32.
   function automatic txfil_ctrl_s f_tx(input logic [64:1] w);
      return {w[17], w[18], w[22:20], w[24:23], w[31:25], w[32]};
   endfunction

   // Transceiver fields; capacitor bits run in descending order.
   function automatic trx_ctrl_s f_trx(input logic [64:1] w);
      return {w[24:17], w[32:27], {<<{w[40:33]}}, w[45:41], w[49], w[50], w[51], w[52],
              w[56:54], w[57], w[58], w[59], w[60], w[63:61], w[64]};
   endfunction

   // Every output after reset is zero.
   task automatic zero_exp();
      e_tx = '0;
      e_trx = '0;
      e_stb = '0;
      e_band = '0;
      e_tif = '0;
      e_wr = '0;
   endtask

   task automatic check_all();
      `CHK("txfil_ctrl", e_tx, txfil_ctrl);
      `CHK("trx_ctrl", e_trx, trx_ctrl);
      `CHK("trx_strobe", e_stb, trx_strobe);
      `CHK("band_ctrl", e_band, band_ctrl);
      `CHK("tif_ctrl", e_tif, tif_ctrl);
      `CHK("wr_ctrl", e_wr, wr_ctrl);
   endtask

   // Moves the gates, waits for the synchroniser and the downstream registers.
   task automatic set_gates(input logic g1, input logic g2);
      logic [16:1] w;
      gate1 = g1;
      gate2 = g2;
      repeat (8) @(posedge clk);
      #1;
      e_stb = g1 ? w1[5:1] : 5'h00;
      if (g1 && w1[1])
         e_band = {w1[20:17], w1[21], w1[24]};
      if (g1 && w1[11])
         e_tif[10:8] = {w1[22], w1[23], w1[24]};
      if (g1 && w1[12])
         e_tif[7:0] = {w1[17], w1[20:18], w1[23:21], w1[24]};
      for (int r = 0; r < WR_COUNT; r++)
      begin
         w = (r == 0) ? w2 : w3;
         e_wr[r][8] = g2 & w[4];
         if (g2 && w[3])
            e_wr[r][7:0] = {w[12:9], w[13], w[14], w[16:15]};
      end
   endtask

   // Main sequence: random words with corner rounds of all ones and all zeros.
   initial
   begin
      rst_n = 1'b0;
      gate1 = 1'b0;
      gate2 = 1'b0;
      zero_exp();
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'b1;
      check_all();
      for (int it = 0; it < 8; it++)
      begin
         w1 = {$random(seed), $random(seed)};
         w2 = 16'($random(seed));
         w3 = 16'($random(seed));
         go = 2'($random(seed));
         if (it < 2)
         begin
            w1 = (it == 0) ? '1 : '0;
            w2 = w1[16:1];
            w3 = w1[16:1];
            go = 2'h3;
         end
         else if (it % 2 == 1)
         begin
            // Force the strobe bits so the gated registers load whenever this round opens their gate.
            w1[1] = 1'b1;
            w1[11] = 1'b1;
            w1[12] = 1'b1;
            w2[3] = 1'b1;
            w3[3] = 1'b1;
         end
         ctl.send(w1, w2, w3);
         check_all();
         ctl.latch();
         e_tx = f_tx(w1);
         e_trx = f_trx(w1);
         e_wr[0][10:9] = w2[2:1];
         e_wr[1][10:9] = w3[2:1];
         check_all();
         set_gates(go[0], go[1]);
         check_all();
         set_gates(1'b0, 1'b0);
         check_all();
         $display("round %0d done", it);
      end
      // A second reset after the last round clears every output.
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      zero_exp();
      check_all();
      rst_n = 1'b1;
      summarize();
   end

   // Cuts a hang short; a full run needs about 5500 cycles.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         error_cnt++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
endmodule
`default_nettype wire
